// *** dv/scl_board_model.sv ***
/*
  Board model for the shared strap pins: fitted strap resistors, the
  device's weak pulls and lines that nobody holds.
  Assumes the device's value, enable and pull outputs are connected.
*/
`timescale 1ns/100ps
module scl_board_model
  import scl_pkg::*;
(
  // Clock.
  input wire logic clock,
  // Device pin side.
  input wire logic [scl_pkg::NPIN-1:0] pin_out,
  input wire logic [scl_pkg::NPIN-1:0] pin_oe_n,
  input wire logic [scl_pkg::NPIN-1:0] pin_pull_up,
  // Board resistors.
  input wire logic [scl_pkg::NPIN-1:0] strap_fit,
  input wire logic [scl_pkg::NPIN-1:0] strap_lvl,
  // Resolved levels.
  output logic [scl_pkg::NPIN-1:0] pin_in
);
  // MDIO and the clock outputs have no pull, so a floating line wanders.
  localparam logic [NPIN-1:0] NO_PULL = 16'he010;
  logic wander_reg = 1'b0;

  always_ff @(posedge clock) begin
    wander_reg <= ~wander_reg;
  end

  // A fitted resistor is stronger than the device's weak pull.
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pin_oe_n[i] == 1'b0) begin
        pin_in[i] = pin_out[i];
      end else if (strap_fit[i]) begin
        pin_in[i] = strap_lvl[i];
      end else if (NO_PULL[i]) begin
        pin_in[i] = wander_reg ^ i[0];
      end else begin
        pin_in[i] = pin_pull_up[i];
      end
    end
  end
endmodule

// *** dv/testbench.sv ***
/*
  Self-checking bench for the strap configuration latch.
  Assumes the board model resolves the pins and reads complete in order.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; \
  if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %h expected %h", $time, (a), (b)); \
  end end
module testbench;
  import scl_pkg::*;
  localparam int BH = 8;
  logic clock = 1'b0;
  logic reset_n;
  logic [AW-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [DW-1:0] avs_writedata, avs_readdata, exp_rd;
  logic [3:0] avs_byteenable;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe_n, pin_pull_up;
  logic [NPIN-1:0] core_pin_out, core_pin_en, strap_fit, strap_lvl;
  logic link_good, link_activity;
  scl_straps_t straps;
  logic crossover_enable, crossover_force, indicator_mode_one;
  logic an_enable, regulator_off;
  int err_count = 0;
  int total_checks = 0;
  logic [31:0] rng = 32'h0000_0043;
  logic [DW-1:0] rd_q[$];

  scl_strap_latch #(.BLINK_HALF(BH)) uut (.clock(clock), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pull_up(pin_pull_up), .core_pin_out(core_pin_out),
    .core_pin_en(core_pin_en), .link_good(link_good),
    .link_activity(link_activity), .straps(straps),
    .crossover_enable(crossover_enable), .crossover_force(crossover_force),
    .indicator_mode_one(indicator_mode_one), .an_enable(an_enable),
    .regulator_off(regulator_off));

  scl_board_model board (.clock(clock), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up), .strap_fit(strap_fit),
    .strap_lvl(strap_lvl), .pin_in(pin_in));

  initial begin
    forever #2 clock = ~clock;
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task give_verdict;
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task wait_ack;
    int n;
    for (n = 0; n < 64; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 64) begin
      err_count++;
      give_verdict();
    end
  endtask

  task bus_rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge clock);
    rd_q.push_back(e);
    avs_read <= 1'b1;
    avs_address <= a;
    wait_ack();
    avs_read <= 1'b0;
  endtask

  task bus_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clock);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    wait_ack();
    avs_write <= 1'b0;
  endtask

  task do_reset(input int len);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (len) @(posedge clock);
    `CHK(pin_oe_n, {NPIN{1'b1}})
    reset_n <= 1'b1;
  endtask

  task check_cfg(input scl_straps_t s, input logic lg);
    repeat (3) @(posedge clock);
    `CHK(straps, s)
    `CHK(crossover_enable, s.crossover_auto)
    `CHK(indicator_mode_one, s.indicator_style)
    `CHK({an_enable, crossover_force, regulator_off}, 3'b100)
    bus_rd(ADDR_ADVERT, {23'h00_0000, s.duplex_advert ? ADV_FULL : ADV_HALF,
      ADV_SELECTOR});
    bus_rd(ADDR_XCVR_CTRL, {16'h0000, s.crossover_auto, 9'h000,
      s.indicator_style, s.station_addr});
    bus_rd(ADDR_STRAP_STATUS, {21'h00_0000, 1'b1, lg, s.rmii_mode,
      s.crossover_auto, s.indicator_style, s.duplex_advert,
      s.station_addr});
    bus_rd(ADDR_REG_CTRL, REG_CTRL_RESET);
  endtask

  task count_tog(input int cyc, output int t);
    logic last;
    t = 0;
    last = pin_out[3];
    repeat (cyc) begin
      @(posedge clock);
      if (pin_out[3] !== last) t++;
      last = pin_out[3];
    end
  endtask

  // Read answers are matched to the oldest expectation in the queue.
  always @(posedge clock) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      exp_rd = rd_q.pop_front();
      `CHK(avs_readdata, exp_rd)
    end
  end

  initial begin
    scl_straps_t s;
    int t;
    logic [31:0] r;
    reset_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'h3;
    core_pin_out = '0;
    core_pin_en = '0;
    link_good = 1'b0;
    link_activity = 1'b0;
    strap_fit = '0;
    strap_lvl = '0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    do_reset(260);
    check_cfg('{5'h01, 1'b1, 1'b1, 1'b1, 1'b0}, 1'b1);
    bus_wr(ADDR_REG_CTRL, 32'h0000_8000);
    bus_rd(ADDR_REG_CTRL, 32'h0000_8000);
    `CHK(regulator_off, 1'b1)
    bus_wr(12'h7fc, xs());
    bus_rd(12'h7fc, RDATA_NONE);
    // The address field is read-only, so its ones must not stick.
    bus_wr(ADDR_XCVR_CTRL, 32'h0000_401f);
    bus_rd(ADDR_XCVR_CTRL, 32'h0000_4001);
    `CHK({crossover_enable, crossover_force, indicator_mode_one}, 3'b010)
    link_good <= 1'b1;
    link_activity <= 1'b1;
    repeat (4) @(posedge clock);
    count_tog(40, t);
    `CHK(t inside {[4:5]}, 1'b1)
    bus_wr(ADDR_XCVR_CTRL, 32'h0000_8020);
    repeat (4) @(posedge clock);
    count_tog(20, t);
    `CHK({t == 0, pin_out[3], pin_oe_n[3]}, 3'b110)
    link_good <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK(pin_out[3], 1'b0)
    for (int k = 0; k < 7; k++) begin
      r = xs();
      s = r[8:0];
      if (k == 0) s.station_addr = 5'h00;
      if (k == 1) s.station_addr = 5'h1f;
      strap_fit <= 16'h1fe8;
      strap_lvl <= {3'b000, s.station_addr, s.crossover_auto,
        s.indicator_style, s.rmii_mode, 1'b0, s.duplex_advert, 3'b000};
      do_reset(k == 6 ? 20 : 260);
      check_cfg(s, k < 6);
      r = xs();
      strap_lvl <= r[15:0];
      core_pin_out <= r[31:16];
      r = xs();
      core_pin_en <= r[15:0];
      repeat (10) @(posedge clock);
      `CHK(straps, s)
      `CHK(pin_oe_n, ~core_pin_en & 16'hfff7)
      `CHK(pin_out & 16'hfff7, core_pin_out & 16'hfff7)
    end
    give_verdict();
  end
endmodule

// *** hw/scl_pad_ring.sv ***
/*
  Output stage for the shared strap and data pins: one registered
  value and active-low enable per pin, plus the weak pull map.
  Assumes the bench resolves each wire from enable, value and pull.
*/
`timescale 1ns/100ps
module scl_pad_ring
  import scl_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Core side.
  input wire logic [scl_pkg::NPIN-1:0] core_out,
  input wire logic [scl_pkg::NPIN-1:0] core_en,
  // Pin side.
  output logic [scl_pkg::NPIN-1:0] pin_out,
  output logic [scl_pkg::NPIN-1:0] pin_oe_n,
  output logic [scl_pkg::NPIN-1:0] pin_pull_up
);
  genvar i;
  generate
    for (i = 0; i < NPIN; i++) begin : g_pin
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          pin_oe_n[i] <= 1'b1;
          pin_out[i] <= 1'b0;
        end else begin
          pin_oe_n[i] <= ~core_en[i];
          pin_out[i] <= core_out[i];
        end
      end
    end
  endgenerate

  // Undriven straps settle to these pulls, which give the default modes.
  always_ff @(posedge clock) begin
    pin_pull_up <= PIN_PULL_UP;
  end
endmodule

// *** hw/scl_strap_latch.sv ***
/*
  Strap configuration latch: samples the shared strap pins while reset
  is held, keeps them afterwards, drives the link indicator and serves
  the configuration registers on an Avalon-MM slave with waitrequest.
  Assumes the pins are synchronous to clock and reset is synchronous.
*/
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
module scl_strap_latch
  import scl_pkg::*;
#(
  parameter int BLINK_HALF = scl_pkg::BLINK_HALF_CYCLES
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Avalon-MM register slave.
  input wire logic [scl_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [scl_pkg::DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [scl_pkg::DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Shared strap and data pins.
  input wire logic [scl_pkg::NPIN-1:0] pin_in,
  output logic [scl_pkg::NPIN-1:0] pin_out,
  output logic [scl_pkg::NPIN-1:0] pin_oe_n,
  output logic [scl_pkg::NPIN-1:0] pin_pull_up,
  // Core data for the shared pins after reset.
  input wire logic [scl_pkg::NPIN-1:0] core_pin_out,
  input wire logic [scl_pkg::NPIN-1:0] core_pin_en,
  input wire logic link_good,
  input wire logic link_activity,
  // Configuration towards the transceiver core.
  output scl_pkg::scl_straps_t straps,
  output logic crossover_enable,
  output logic crossover_force,
  output logic indicator_mode_one,
  output logic an_enable,
  output logic regulator_off
);
  localparam int BLINK_W = $clog2(BLINK_HALF + 1);
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_HALF - 1);

  scl_straps_t straps_reg;
  scl_straps_t sampled;
  scl_bus_state_t bus_state_reg;
  logic [REG_W-1:0] advert_reg;
  logic [REG_W-1:0] xcvr_ctrl_reg;
  logic [REG_W-1:0] reg_ctrl_reg;
  logic [REG_W-1:0] status_word;
  logic [DW-1:0] readdata_reg;
  logic [DW-1:0] rd_data_next;
  logic waitrequest_reg;
  logic ack;
  logic wr_xcvr;
  logic wr_advert;
  logic wr_regctl;
  logic [RST_CNT_W-1:0] rst_cnt_reg;
  logic reset_long_reg;
  logic reset_prev_reg;
  logic [BLINK_W-1:0] blink_cnt_reg;
  logic blink_phase_reg;
  logic ind_level_reg;
  logic ind_level_next;
  logic [NPIN-1:0] drive_out;
  logic [NPIN-1:0] drive_en;

  // Strap levels as seen on the pins this cycle.
  always_comb begin
    sampled.station_addr = {pin_in[PIN_RXD3:PIN_RXD0], pin_in[PIN_COL]};
    sampled.duplex_advert = pin_in[PIN_LED];
    sampled.indicator_style = pin_in[PIN_CRS];
    sampled.crossover_auto = pin_in[PIN_RX_ER];
    sampled.rmii_mode = pin_in[PIN_RX_DV];
  end

  // The pins are re-sampled on every reset cycle, so the last level wins.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      straps_reg <= sampled;
    end
  end

  // Previous reset level, so the first low edge of a reset restarts the
  // count even at power-up, when the counter holds no known value.
  always_ff @(posedge clock) begin
    reset_prev_reg <= reset_n;
  end

  // Reset length tracking; the counter runs only while reset is low.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      if (!reset_prev_reg) begin
        if (rst_cnt_reg != '1) begin
          rst_cnt_reg <= rst_cnt_reg + 1'b1;
        end
      end else begin
        rst_cnt_reg <= RST_CNT_W'(1);
      end
      reset_long_reg <= (rst_cnt_reg >= RESET_LONG_AT);
    end else begin
      rst_cnt_reg <= '0;
    end
  end

  // Bus handshake: one wait cycle, then a single cycle with
  // waitrequest low, at whose closing edge the access completes.
  assign ack = (avs_read || avs_write) && !waitrequest_reg;
  assign wr_xcvr = ack && avs_write && avs_address == ADDR_XCVR_CTRL;
  assign wr_advert = ack && avs_write && avs_address == ADDR_ADVERT;
  assign wr_regctl = ack && avs_write && avs_address == ADDR_REG_CTRL;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bus_state_reg <= BUS_IDLE;
      waitrequest_reg <= 1'b1;
    end else begin
      unique case (bus_state_reg)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_reg <= BUS_ACK;
            waitrequest_reg <= 1'b0;
          end
        end
        BUS_ACK: begin
          bus_state_reg <= BUS_IDLE;
          waitrequest_reg <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    status_word = '0;
    status_word[4:0] = straps_reg.station_addr;
    status_word[ST_DUPLEX] = straps_reg.duplex_advert;
    status_word[ST_IND] = straps_reg.indicator_style;
    status_word[ST_XOVER] = straps_reg.crossover_auto;
    status_word[ST_RMII] = straps_reg.rmii_mode;
    status_word[ST_RST_LONG] = reset_long_reg;
    status_word[ST_AN_EN] = an_enable;
  end

  // Unmapped addresses read as zero and ignore writes.
  always_comb begin
    rd_data_next = RDATA_NONE;
    unique case (avs_address)
      ADDR_ADVERT: rd_data_next[REG_W-1:0] = advert_reg;
      ADDR_XCVR_CTRL: rd_data_next[REG_W-1:0] = xcvr_ctrl_reg;
      ADDR_STRAP_STATUS: rd_data_next[REG_W-1:0] = status_word;
      ADDR_REG_CTRL: rd_data_next[REG_W-1:0] = reg_ctrl_reg;
      default: rd_data_next = RDATA_NONE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      readdata_reg <= RDATA_NONE;
    end else if (avs_read && waitrequest_reg &&
        bus_state_reg == BUS_IDLE) begin
      readdata_reg <= rd_data_next;
    end
  end

  // Advertisement register; its ability field follows the duplex strap.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      advert_reg <= '0;
      advert_reg[4:0] <= ADV_SELECTOR;
      advert_reg[ADV_MSB:ADV_LSB] <= sampled.duplex_advert ?
        ADV_FULL : ADV_HALF;
      an_enable <= 1'b1;
    end else begin
      if (wr_advert && avs_byteenable[0]) begin
        advert_reg[7:0] <= avs_writedata[7:0];
      end
      if (wr_advert && avs_byteenable[1]) begin
        advert_reg[15:8] <= avs_writedata[15:8];
      end
    end
  end

  // Transceiver control; the address field mirrors the latched straps.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      xcvr_ctrl_reg <= '0;
      xcvr_ctrl_reg[XC_XOVER_AUTO] <= sampled.crossover_auto;
      xcvr_ctrl_reg[XC_IND_MODE] <= sampled.indicator_style;
    end else begin
      if (wr_xcvr && avs_byteenable[0]) begin
        xcvr_ctrl_reg[XC_IND_MODE] <= avs_writedata[XC_IND_MODE];
      end
      if (wr_xcvr && avs_byteenable[1]) begin
        xcvr_ctrl_reg[XC_XOVER_AUTO] <= avs_writedata[XC_XOVER_AUTO];
        xcvr_ctrl_reg[XC_XOVER_FORCE] <= avs_writedata[XC_XOVER_FORCE];
      end
      xcvr_ctrl_reg[4:0] <= straps_reg.station_addr;
    end
  end

  // Regulator control; only the shutdown bit is implemented.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_ctrl_reg <= REG_CTRL_RESET;
    end else if (wr_regctl && avs_byteenable[1]) begin
      reg_ctrl_reg[RC_REG_OFF] <= avs_writedata[RC_REG_OFF];
    end
  end

  // Blink timer runs only during activity in mode two, so an idle link
  // shows a steady light rather than a frozen half-phase.
  always_ff @(posedge clock) begin
    if (!reset_n || !link_activity || xcvr_ctrl_reg[XC_IND_MODE]) begin
      blink_cnt_reg <= '0;
      blink_phase_reg <= 1'b0;
    end else if (blink_cnt_reg == BLINK_LAST) begin
      blink_cnt_reg <= '0;
      blink_phase_reg <= ~blink_phase_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 1'b1;
    end
  end

  always_comb begin
    if (xcvr_ctrl_reg[XC_IND_MODE]) begin
      ind_level_next = link_good;
    end else begin
      ind_level_next = link_good && !blink_phase_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ind_level_reg <= 1'b0;
    end else begin
      ind_level_reg <= ind_level_next;
    end
  end

  // The indicator owns its shared pin once reset has gone.
  always_comb begin
    drive_out = core_pin_out;
    drive_en = core_pin_en;
    drive_out[PIN_LED] = ind_level_reg;
    drive_en[PIN_LED] = 1'b1;
  end

  scl_pad_ring u_pads (
    .clock(clock),
    .reset_n(reset_n),
    .core_out(drive_out),
    .core_en(drive_en),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pin_pull_up(pin_pull_up)
  );

  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;
  assign straps = straps_reg;
  assign crossover_enable = xcvr_ctrl_reg[XC_XOVER_AUTO];
  assign crossover_force = xcvr_ctrl_reg[XC_XOVER_FORCE];
  assign indicator_mode_one = xcvr_ctrl_reg[XC_IND_MODE];
  assign regulator_off = reg_ctrl_reg[RC_REG_OFF];

  strap_sample_a: assert property (@(posedge clock)
    disable iff (!reset_n)
    $rose(reset_n) |-> straps_reg == $past(sampled))
    else $error("strap set differs from last reset sample");

  addr_capture_a: assert property (@(posedge clock)
    disable iff (!reset_n)
    $rose(reset_n) |-> straps_reg.station_addr ==
      $past({pin_in[PIN_RXD3:PIN_RXD0], pin_in[PIN_COL]}))
    else $error("station address not captured from address pins");

  strap_hold_a: assert property (@(posedge clock)
    disable iff (!reset_n)
    $past(reset_n) |-> $stable(straps_reg) ##1 $stable(straps_reg))
    else $error("latched straps changed outside reset");

  addr_mirror_a: assert property (@(posedge clock)
    disable iff (!reset_n)
    $past(reset_n) |-> xcvr_ctrl_reg[4:0] == $past(straps_reg.station_addr))
    else $error("address field does not mirror latched address");

  advert_duplex_a: assert property (@(posedge clock)
    disable iff (!reset_n)
    $rose(reset_n) |-> advert_reg[ADV_MSB:ADV_LSB] ==
      ($past(pin_in[PIN_LED]) ? ADV_FULL : ADV_HALF) && an_enable)
    else $error("advertised abilities do not follow duplex strap");

  xover_strap_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(reset_n) |-> crossover_enable == $past(pin_in[PIN_RX_ER]))
    else $error("crossover enable does not follow its strap");

  rmii_strap_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(reset_n) |-> straps.rmii_mode == $past(pin_in[PIN_RX_DV]))
    else $error("port type does not follow its strap");

  pins_float_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(reset_n) |-> &pin_oe_n ##1 pin_oe_n[PIN_LED] == 1'b0)
    else $error("shared pins not floating at reset release");

  reset_len_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(reset_n) |-> reset_long_reg ==
      ($past(rst_cnt_reg) >= RESET_LONG_AT))
    else $error("reset length flag wrong");

  ind_override_a: assert property (@(posedge clock)
    disable iff (!reset_n)
    wr_xcvr && avs_byteenable[0] |=>
      indicator_mode_one == $past(avs_writedata[XC_IND_MODE]))
    else $error("indicator mode write not taken");

  ind_mode_one_a: assert property (@(posedge clock)
    disable iff (!reset_n)
    indicator_mode_one && $stable(indicator_mode_one) |->
      ##1 (ind_level_reg == $past(link_good)) ##1
      (pin_out[PIN_LED] == $past(ind_level_reg)))
    else $error("mode one indicator does not follow link");

  bus_answer_a: assert property (@(posedge clock) disable iff (!reset_n)
    (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
    else $error("bus request not answered within two cycles");

  read_cov: cover property (@(posedge clock) disable iff (!reset_n)
    ack && avs_read && avs_address == ADDR_STRAP_STATUS);
  mode_write_cov: cover property (@(posedge clock) disable iff (!reset_n)
    wr_xcvr);
  blink_cov: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(blink_phase_reg));
  rmii_cov: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(reset_n) && straps.rmii_mode);
endmodule

// *** pkg/scl_pkg.sv ***
/*
  Constants and types for the strap configuration latch: register map,
  field positions, reset values, pin indices and timing counts.
  Assumes a 250 MHz core clock and a 32-bit Avalon-MM register bus.
*/
package scl_pkg;
  // Clock and timing.
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYCLES =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 9;
  localparam logic [RST_CNT_W-1:0] RESET_LONG_AT =
    RST_CNT_W'(RESET_MIN_CYCLES - 1);
  localparam int BLINK_HALF_NS = 100_000_000;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_NS / CLK_PERIOD_NS;

  // Bus and register widths.
  localparam int AW = 12;
  localparam int DW = 32;
  localparam int REG_W = 16;

  // Register indices; the byte address is four times the index.
  localparam logic [AW-1:0] IDX_ADVERT = 12'h004;
  localparam logic [AW-1:0] IDX_XCVR_CTRL = 12'h019;
  localparam logic [AW-1:0] IDX_STRAP_STATUS = 12'h01c;
  localparam logic [AW-1:0] IDX_REG_CTRL = 12'h0d0;
  localparam logic [AW-1:0] ADDR_ADVERT = {IDX_ADVERT[AW-3:0], 2'b00};
  localparam logic [AW-1:0] ADDR_XCVR_CTRL = {IDX_XCVR_CTRL[AW-3:0], 2'b00};
  localparam logic [AW-1:0] ADDR_STRAP_STATUS =
    {IDX_STRAP_STATUS[AW-3:0], 2'b00};
  localparam logic [AW-1:0] ADDR_REG_CTRL = {IDX_REG_CTRL[AW-3:0], 2'b00};

  // Field positions.
  localparam int XC_XOVER_AUTO = 15;
  localparam int XC_XOVER_FORCE = 14;
  localparam int XC_IND_MODE = 5;
  localparam int RC_REG_OFF = 15;
  localparam int ADV_LSB = 5;
  localparam int ADV_MSB = 8;
  localparam int ST_DUPLEX = 5;
  localparam int ST_IND = 6;
  localparam int ST_XOVER = 7;
  localparam int ST_RMII = 8;
  localparam int ST_RST_LONG = 9;
  localparam int ST_AN_EN = 10;

  // Values after reset and field encodings.
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  localparam logic [3:0] ADV_FULL = 4'hf;
  localparam logic [3:0] ADV_HALF = 4'h5;
  localparam logic [REG_W-1:0] REG_CTRL_RESET = 16'h0000;
  localparam logic [DW-1:0] RDATA_NONE = 32'h0000_0000;

  // Shared pin indices.
  localparam int NPIN = 16;
  localparam int PIN_TXD3 = 0;
  localparam int PIN_TX_EN = 1;
  localparam int PIN_IRQ = 2;
  localparam int PIN_LED = 3;
  localparam int PIN_MDIO = 4;
  localparam int PIN_RX_DV = 5;
  localparam int PIN_CRS = 6;
  localparam int PIN_RX_ER = 7;
  localparam int PIN_COL = 8;
  localparam int PIN_RXD0 = 9;
  localparam int PIN_RXD3 = 12;
  localparam int PIN_TX_CLK = 13;
  localparam int PIN_CLK25 = 14;
  localparam int PIN_RX_CLK = 15;
  // Weak pull direction per pin, one means pull-up.
  localparam logic [NPIN-1:0] PIN_PULL_UP = 16'h01cc;

  typedef struct packed {
    logic [4:0] station_addr;
    logic duplex_advert;
    logic indicator_style;
    logic crossover_auto;
    logic rmii_mode;
  } scl_straps_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } scl_bus_state_t;
endpackage
